// ### rtc_alarm_protect_fout_control_tb_top.sv
// Self-checking bench for the control block: registers, protect, alarms, pin select, trim.
// Assumes the host model drives the strobes; the bench drives time, clock sources and array.
`timescale 1ns/10ps
module rtc_alarm_protect_fout_control_tb_top;
    import rtc_ctl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic time_tick = 1'b0;
    logic osc_32k = 1'b0;
    logic div_4k = 1'b0;
    logic div_1hz = 1'b0;
    logic [7:0] status_in = 8'h08;
    time_s now = '0;
    arr_wr_s arr_req = '0;
    wire ctl_wr, alarm_wr, alarm_sel, status_rd_done, pin;
    wire [2:0] ctl_addr, alarm_field;
    wire [7:0] ctl_wdata, alarm_wdata, sr, prot_r, irq_r, trim_r;
    wire [6:0] cap;
    arr_wr_s commit;
    int n_errors = 0;
    int check_count = 0;
    int cnt;
    logic [2:0] sel;
    int rises;
    logic prev;
    logic [7:0] exp_cap;

    always #12.5 clk = ~clk;

    rtc_host_model u_host (.clk(clk), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr),
        .ctl_wdata(ctl_wdata), .alarm_wr(alarm_wr), .alarm_sel(alarm_sel),
        .alarm_field(alarm_field), .alarm_wdata(alarm_wdata), .status_rd_done(status_rd_done));
    rtc_ctl u_dut (.clk(clk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr),
        .ctl_wdata(ctl_wdata), .alarm_wr(alarm_wr), .alarm_sel(alarm_sel),
        .alarm_field(alarm_field), .alarm_wdata(alarm_wdata), .status_rd_done(status_rd_done),
        .status_in(status_in), .now(now), .time_tick(time_tick), .osc_32k(osc_32k),
        .div_4k(div_4k), .div_1hz(div_1hz), .arr_req(arr_req), .status_reg(sr),
        .array_protect_watchdog_ctl(prot_r), .alarm_irq_freq_out_ctl(irq_r),
        .load_cap_trim(trim_r), .arr_commit(commit), .irq_clock_out_pin(pin),
        .cap_half_pf(cap));

    // Byte compare; single bits are zero-extended by the caller
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // Locked range per protect code, worked out independently of the design
    function automatic logic prot(input logic [2:0] c, input logic [8:0] a);
        case (c)
            3'h1: return a >= 9'h180;
            3'h2: return a >= 9'h100;
            3'h3, 3'h7: return 1'b1;
            3'h4: return a <= 9'h03f;
            3'h5: return a <= 9'h07f;
            3'h6: return a <= 9'h0ff;
            default: return 1'b0;
        endcase
    endfunction : prot

    // One counter advance; pin and flags settle within three cycles
    task automatic tick(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s);
        @(posedge clk);
        #1;
        now = {24'h0, h, m, s};
        time_tick = 1'b1;
        @(posedge clk);
        #1;
        time_tick = 1'b0;
    endtask : tick

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // Hang guard: a run this long counts as a mismatch
    initial begin
        #2000000;
        n_errors++;
        end_sim();
    end

    initial begin
        logic [8:0] addrs [10] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080, 9'h0ff, 9'h100,
            9'h17f, 9'h180, 9'h1ff};
        logic [5:0] codes [4] = '{6'h00, 6'h20, 6'h1f, 6'h15};
        wait_cyc(10);
        rst_b = 1'b1;
        wait_cyc(2);
        chk(prot_r, 8'h18);
        chk(irq_r, 8'h00);
        chk(trim_r, 8'h00);
        chk(sr, 8'h00);
        // Outside status bits pass through; bit 3 and the flag positions do not
        status_in = 8'hff;
        wait_cyc(2);
        chk(sr, 8'h97);
        status_in = 8'h08;
        // Unused bits read back as zero
        u_host.wr_ctl(3'h0, 8'hff);
        u_host.wr_ctl(3'h1, 8'hff);
        u_host.wr_ctl(3'h2, 8'hff);
        wait_cyc(1);
        chk(prot_r, 8'hf8);
        chk(irq_r, 8'hf8);
        chk(trim_r, 8'h3f);
        u_host.wr_ctl(3'h1, 8'h00);
        // Capacitance per trim code, in half-picofarad units
        foreach (codes[i]) begin
            u_host.wr_ctl(3'h2, {2'h0, codes[i]});
            wait_cyc(3);
            exp_cap = {2'h0, ~codes[i][5], 5'h0} + {3'h0, codes[i][4:0]} + 8'h12;
            chk({1'b0, cap}, exp_cap);
        end
        // Every protect code against every range boundary
        for (int c = 0; c < 8; c++) begin
            u_host.wr_ctl(3'h0, {3'(c), 5'h0});
            wait_cyc(1);
            foreach (addrs[i]) begin
                arr_req = '{1'b1, addrs[i], 8'(i) ^ 8'h5a};
                wait_cyc(1);
                chk({7'h0, commit.valid}, {7'h0, ~prot(3'(c), addrs[i])});
                if (commit.valid === 1'b1) begin
                    chk(commit.data, 8'(i) ^ 8'h5a);
                    chk(commit.addr[7:0], addrs[i][7:0]);
                    chk({7'h0, commit.addr[8]}, {7'h0, addrs[i][8]});
                end
            end
            arr_req = '0;
        end
        // Alarm A on second and minute; alarm B on hour only
        u_host.wr_alarm(1'b0, 3'h0, 8'hb0);
        u_host.wr_alarm(1'b0, 3'h1, 8'h95);
        u_host.wr_alarm(1'b1, 3'h2, 8'h88);
        u_host.wr_ctl(3'h1, 8'h20);
        tick(8'h23, 8'h15, 8'h31);
        wait_cyc(3);
        chk(sr, 8'h00);
        chk({7'h0, pin}, 8'h00);
        tick(8'h23, 8'h15, 8'h30);
        wait_cyc(3);
        chk(sr, 8'h20);
        chk({7'h0, pin}, 8'h01);
        u_host.rd_status();
        wait_cyc(3);
        chk(sr, 8'h00);
        chk({7'h0, pin}, 8'h00);
        // Flags set with the interrupt disabled
        u_host.wr_ctl(3'h1, 8'h00);
        tick(8'h23, 8'h15, 8'h30);
        wait_cyc(3);
        chk(sr, 8'h20);
        chk({7'h0, pin}, 8'h00);
        u_host.rd_status();
        // Pulsed mode, both alarms: one pulse per match
        u_host.wr_ctl(3'h1, 8'he0);
        // Third match hits both alarms in one tick: two pulses with a gap between
        for (int k = 0; k < 3; k++) begin
            if (k == 0) tick(8'h07, 8'h15, 8'h30);
            else if (k == 1) tick(8'h08, 8'h00, 8'h00);
            else tick(8'h08, 8'h15, 8'h30);
            cnt = 0;
            rises = 0;
            prev = 1'b0;
            for (int i = 0; i < 24; i++) begin
                wait_cyc(1);
                cnt += int'(pin === 1'b1);
                rises += int'(pin === 1'b1 && prev !== 1'b1);
                prev = pin;
            end
            chk(8'(cnt), 8'((k == 2 ? 2 : 1) * IRQ_PULSE_CYC));
            chk(8'(rises), (k == 2) ? 8'h02 : 8'h01);
        end
        chk(sr, 8'h60);
        // Clock select overrides a pending alarm
        for (int f = 1; f < 4; f++) begin
            u_host.wr_ctl(3'h1, {3'h1, 2'(f), 3'h0});
            for (int v = 0; v < 2; v++) begin
                sel = 3'(1 << (f - 1));
                if (v == 1) sel = ~sel;
                {div_1hz, div_4k, osc_32k} = sel;
                if (v == 1) tick(8'h23, 8'h15, 8'h30);
                wait_cyc(4);
                chk({7'h0, pin}, {7'h0, v == 0});
            end
        end
        // Back to alarm output: the suppressed match left nothing on the pin
        u_host.wr_ctl(3'h1, 8'h20);
        wait_cyc(3);
        chk({7'h0, pin}, 8'h00);
        end_sim();
    end
endmodule : rtc_alarm_protect_fout_control_tb_top

// ### rtc_ctl.sv
// Control block of a clock/calendar device: two alarms, array protect, irq/clock pin, cap trim.
// Assumes the serial slave upstream delivers decoded byte writes and read strobes on clk.
`timescale 1ns/10ps
module rtc_ctl
    import rtc_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ctl_wr,
    input wire logic [2:0] ctl_addr,
    input wire logic [7:0] ctl_wdata,
    input wire logic alarm_wr,
    input wire logic alarm_sel,
    input wire logic [2:0] alarm_field,
    input wire logic [7:0] alarm_wdata,
    input wire logic status_rd_done,
    input wire logic [7:0] status_in,
    input wire rtc_ctl_pkg::time_s now,
    input wire logic time_tick,
    input wire logic osc_32k,
    input wire logic div_4k,
    input wire logic div_1hz,
    input wire rtc_ctl_pkg::arr_wr_s arr_req,
    output logic [7:0] status_reg,
    output logic [7:0] array_protect_watchdog_ctl,
    output logic [7:0] alarm_irq_freq_out_ctl,
    output logic [7:0] load_cap_trim,
    output rtc_ctl_pkg::arr_wr_s arr_commit,
    output logic irq_clock_out_pin,
    output logic [6:0] cap_half_pf
);
    import rtc_ctl_pkg::*;

    // Field compare: disabled field always matches, enabled needs equal low seven bits
    function automatic logic field_hit(input logic [7:0] a, input logic [7:0] t);
        field_hit = !a[ENABLE_BIT] || (a[ENABLE_BIT-1:0] == t[ENABLE_BIT-1:0]);
    endfunction : field_hit

    // Protect decode for a nine-bit array address
    function automatic logic is_locked(input logic [2:0] code, input logic [8:0] a);
        unique case (code)
            3'h0: is_locked = 1'b0;
            3'h1: is_locked = a >= ARR_QUARTER_HI;
            3'h2: is_locked = a >= ARR_HALF_HI;
            3'h4: is_locked = a <= ARR_PAGES4_END;
            3'h5: is_locked = a <= ARR_PAGES8_END;
            3'h6: is_locked = a <= ARR_PAGES16_END;
            default: is_locked = (a >= ARR_FIRST) && (a <= ARR_LAST);
        endcase
    endfunction : is_locked

    // Alarm storage; the array stands in for the non-volatile cells
    logic [7:0] alarm_mem [2][NUM_FIELDS];
    logic [1:0] flags;
    logic pulse_pend;
    logic [3:0] pulse_cnt;
    logic irq_level;

    wire [2:0] prot_code = array_protect_watchdog_ctl[PROT_CODE_LSB +: 3];
    wire pulsed = alarm_irq_freq_out_ctl[IRQ_PULSED_BIT];
    wire [1:0] irq_en = {alarm_irq_freq_out_ctl[IRQ_EN_B_BIT],
                         alarm_irq_freq_out_ctl[IRQ_EN_A_BIT]};
    wire [1:0] fsel = alarm_irq_freq_out_ctl[FREQ_SEL_LSB +: 2];
    wire [5:0] trim = load_cap_trim[5:0];

    // Per-alarm field matches, year never compared
    logic [1:0] hit;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_alarm
            wire [NUM_FIELDS-1:0] fh;
            assign fh[0] = field_hit(alarm_mem[g][0], now.second);
            assign fh[1] = field_hit(alarm_mem[g][1], now.minute);
            assign fh[2] = field_hit(alarm_mem[g][2], now.hour);
            assign fh[3] = field_hit(alarm_mem[g][3], now.date);
            assign fh[4] = field_hit(alarm_mem[g][4], now.month);
            assign fh[5] = field_hit(alarm_mem[g][5], now.weekday);
            // Any subset of enables works; an all-disabled alarm never fires
            assign hit[g] = time_tick && (&fh) &&
                            (|{alarm_mem[g][0][ENABLE_BIT], alarm_mem[g][1][ENABLE_BIT],
                               alarm_mem[g][2][ENABLE_BIT], alarm_mem[g][3][ENABLE_BIT],
                               alarm_mem[g][4][ENABLE_BIT], alarm_mem[g][5][ENABLE_BIT]});
        end
    endgenerate

    // Alarm events that may signal on the pin
    wire irq_allowed = (|irq_en) && (fsel == FSEL_ALARM);
    wire [1:0] irq_hit = hit & irq_en;
    // Set wins over the read clear so no match is lost
    wire [1:0] next_flags = hit | (status_rd_done ? 2'h0 : flags);
    // Level irq holds until status read; pulsed mode pulses once per match but holds at most one match waiting
    wire next_irq_level = irq_allowed && !pulsed &&
                          ((|irq_hit) || (irq_level && !status_rd_done));
    wire pulse_mode = irq_allowed && pulsed;
    wire pulse_on = pulse_cnt != 4'h0;
    // A match inside a running pulse, or the second of two same-tick matches, waits for
    // the pin to drop so each alarm gets its own pulse; only one match is queued
    wire start_pulse = pulse_mode && !pulse_on && ((|irq_hit) || pulse_pend);
    wire next_pulse_pend = pulse_mode &&
                           (pulse_on ? (pulse_pend || (|irq_hit))
                                     : (pulse_pend ? (|irq_hit) : (&irq_hit)));

    // Pin source selection
    logic pin_src;
    always_comb begin
        unique case (fsel)
            FSEL_ALARM: pin_src = irq_level || pulse_on;
            FSEL_32K: pin_src = osc_32k;
            FSEL_4K: pin_src = div_4k;
            FSEL_1HZ: pin_src = div_1hz;
        endcase
    end

    // Capacitance per pin in half-pF units: inverted top bit weighs 16 pF
    wire [6:0] next_cap = CAP_BASE_HALF_PF + (trim[5] ? 7'h00 : CAP_TOP_HALF_PF)
                          + {2'h0, trim[4:0]};

    // Array write gating
    wire arr_locked = is_locked(prot_code, arr_req.addr);
    arr_wr_s next_commit;
    always_comb begin
        next_commit = arr_req;
        next_commit.valid = arr_req.valid && !arr_locked;
    end

    // Status image: unused bit forced zero, alarm flags inserted
    logic [7:0] next_status;
    always_comb begin
        next_status = status_in;
        next_status[STATUS_FLAG_B_BIT] = next_flags[1];
        next_status[STATUS_FLAG_A_BIT] = next_flags[0];
        next_status[STATUS_UNUSED_BIT] = 1'b0;
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            array_protect_watchdog_ctl <= PROTECT_RESET;
            alarm_irq_freq_out_ctl <= IRQ_CLOCK_OUT_PIN_RESET;
            load_cap_trim <= TRIM_RESET;
        end else if (ctl_wr) begin
            if (ctl_addr == ADDR_PROTECT) array_protect_watchdog_ctl <= ctl_wdata & PROTECT_MASK;
            if (ctl_addr == ADDR_IRQ_CLOCK_OUT_PIN) alarm_irq_freq_out_ctl <= ctl_wdata & IRQ_CLOCK_OUT_PIN_MASK;
            if (ctl_addr == ADDR_TRIM) load_cap_trim <= ctl_wdata & TRIM_MASK;
        end
    end

    // Alarm byte storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 2; i++) begin
                for (int j = 0; j < NUM_FIELDS; j++) begin
                    alarm_mem[i][j] <= 8'h00;
                end
            end
        end else if (alarm_wr && (int'(alarm_field) < NUM_FIELDS)) begin
            alarm_mem[alarm_sel][alarm_field] <= alarm_wdata;
        end
    end

    // Flags, pin state and outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= 2'h0;
            pulse_pend <= 1'b0;
            irq_level <= 1'b0;
            pulse_cnt <= 4'h0;
            status_reg <= 8'h00;
            arr_commit <= '0;
            irq_clock_out_pin <= 1'b0;
            cap_half_pf <= 7'h00;
        end else begin
            flags <= next_flags;
            pulse_pend <= next_pulse_pend;
            irq_level <= next_irq_level;
            pulse_cnt <= start_pulse ? 4'(IRQ_PULSE_CYC) : (pulse_on ? pulse_cnt - 4'h1 : 4'h0);
            status_reg <= next_status;
            arr_commit <= next_commit;
            irq_clock_out_pin <= pin_src;
            cap_half_pf <= next_cap;
        end
    end

    // Assertions
    property p_status_bit3;
        @(posedge clk) disable iff (!rst_b) !status_reg[STATUS_UNUSED_BIT];
    endproperty
    a_status_bit3: assert property (p_status_bit3) else $error("status bit 3 not zero");

    property p_locked_drop;
        @(posedge clk) disable iff (!rst_b)
            (arr_req.valid && is_locked(prot_code, arr_req.addr)) |=> !arr_commit.valid;
    endproperty
    a_locked_drop: assert property (p_locked_drop) else $error("locked write passed");

    property p_full_lock;
        @(posedge clk) disable iff (!rst_b)
            (arr_req.valid && prot_code == 3'h3) |=> !arr_commit.valid;
    endproperty
    a_full_lock: assert property (p_full_lock) else $error("full lock leaked");

    property p_free_pass;
        @(posedge clk) disable iff (!rst_b)
            (arr_req.valid && prot_code == 3'h0) |=> arr_commit.valid;
    endproperty
    a_free_pass: assert property (p_free_pass) else $error("unprotected write lost");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b) hit[0] |=> flags[0] && status_reg[STATUS_FLAG_A_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("alarm flag not set");

    property p_flag_clear;
        @(posedge clk) disable iff (!rst_b) (status_rd_done && !hit[1]) |=> !flags[1];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_fsel_32k;
        @(posedge clk) disable iff (!rst_b)
            (fsel == FSEL_32K) |=> irq_clock_out_pin == $past(osc_32k);
    endproperty
    a_fsel_32k: assert property (p_fsel_32k) else $error("clock route wrong");

    property p_suppress;
        @(posedge clk) disable iff (!rst_b) (fsel != FSEL_ALARM) |=> !irq_level;
    endproperty
    a_suppress: assert property (p_suppress) else $error("alarm active with clock out");

    property p_pulse;
        @(posedge clk) disable iff (!rst_b) start_pulse |=> pulse_on [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too short");

    property p_cap_code0;
        @(posedge clk) disable iff (!rst_b) (trim == 6'h00) |=> cap_half_pf == 7'h32;
    endproperty
    a_cap_code0: assert property (p_cap_code0) else $error("trim code 0 wrong");

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_b) !(|irq_en) |=> !irq_level;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq with no enable");

    property p_irq_set;
        @(posedge clk) disable iff (!rst_b)
            (irq_allowed && !pulsed && (|irq_hit)) |=> irq_level;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("level irq not set");

    property p_level_release;
        @(posedge clk) disable iff (!rst_b) (status_rd_done && !(|irq_hit)) |=> !irq_level;
    endproperty
    a_level_release: assert property (p_level_release) else $error("irq held");

    property p_second_pulse;
        @(posedge clk) disable iff (!rst_b) (start_pulse && (&irq_hit)) |=> pulse_pend;
    endproperty
    a_second_pulse: assert property (p_second_pulse) else $error("pulse lost");

    property p_flag_b_set;
        @(posedge clk) disable iff (!rst_b)
            hit[1] |=> flags[1] && status_reg[STATUS_FLAG_B_BIT];
    endproperty
    a_flag_b_set: assert property (p_flag_b_set) else $error("alarm b flag not set");

    property p_commit_copy;
        @(posedge clk) disable iff (!rst_b)
            arr_req.valid |=> (arr_commit.addr == $past(arr_req.addr)) &&
                              (arr_commit.data == $past(arr_req.data));
    endproperty
    a_commit_copy: assert property (p_commit_copy) else $error("array write altered");

    property p_fsel_4k;
        @(posedge clk) disable iff (!rst_b)
            (fsel == FSEL_4K) |=> irq_clock_out_pin == $past(div_4k);
    endproperty
    a_fsel_4k: assert property (p_fsel_4k) else $error("4k route wrong");

    property p_fsel_1hz;
        @(posedge clk) disable iff (!rst_b)
            (fsel == FSEL_1HZ) |=> irq_clock_out_pin == $past(div_1hz);
    endproperty
    a_fsel_1hz: assert property (p_fsel_1hz) else $error("1hz route wrong");

    property p_pin_quiet;
        @(posedge clk) disable iff (!rst_b)
            (fsel == FSEL_ALARM && !irq_level && !pulse_on) |=> !irq_clock_out_pin;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("pin active with no alarm");

    property p_cap_max;
        @(posedge clk) disable iff (!rst_b) (trim == 6'h1f) |=> cap_half_pf == 7'h51;
    endproperty
    a_cap_max: assert property (p_cap_max) else $error("trim code 1f wrong");

    property p_cap_min;
        @(posedge clk) disable iff (!rst_b) (trim == 6'h20) |=> cap_half_pf == 7'h12;
    endproperty
    a_cap_min: assert property (p_cap_min) else $error("trim code 20 wrong");

endmodule : rtc_ctl

// ### rtc_ctl_pkg.sv
// Package for the clock/calendar control block: register fields, protect ranges, trim constants.
// Assumes one 40 MHz clock domain; serial framing is decoded upstream into byte strobes.
package rtc_ctl_pkg;

    // Control register indices (in the control register space)
    localparam logic [2:0] ADDR_PROTECT = 3'h0;
    localparam logic [2:0] ADDR_IRQ_CLOCK_OUT_PIN = 3'h1;
    localparam logic [2:0] ADDR_TRIM = 3'h2;

    // Reset (blank) values
    localparam logic [7:0] PROTECT_RESET = 8'h18;
    localparam logic [7:0] IRQ_CLOCK_OUT_PIN_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // Field positions
    localparam int PROT_CODE_LSB = 5;
    localparam int IRQ_PULSED_BIT = 7;
    localparam int IRQ_EN_B_BIT = 6;
    localparam int IRQ_EN_A_BIT = 5;
    localparam int FREQ_SEL_LSB = 3;
    localparam int STATUS_FLAG_B_BIT = 6;
    localparam int STATUS_FLAG_A_BIT = 5;
    localparam int STATUS_UNUSED_BIT = 3;
    localparam int ENABLE_BIT = 7;

    // Field masks for writes: unused bits stay zero
    localparam logic [7:0] PROTECT_MASK = 8'hf8;
    localparam logic [7:0] IRQ_CLOCK_OUT_PIN_MASK = 8'hf8;
    localparam logic [7:0] TRIM_MASK = 8'h3f;

    // Array protect ranges
    localparam logic [8:0] ARR_LAST = 9'h1ff;
    localparam logic [8:0] ARR_FIRST = 9'h000;
    localparam logic [8:0] ARR_QUARTER_HI = 9'h180;
    localparam logic [8:0] ARR_HALF_HI = 9'h100;
    localparam logic [8:0] ARR_PAGES4_END = 9'h03f;
    localparam logic [8:0] ARR_PAGES8_END = 9'h07f;
    localparam logic [8:0] ARR_PAGES16_END = 9'h0ff;

    // Frequency selection codes
    localparam logic [1:0] FSEL_ALARM = 2'h0;
    localparam logic [1:0] FSEL_32K = 2'h1;
    localparam logic [1:0] FSEL_4K = 2'h2;
    localparam logic [1:0] FSEL_1HZ = 2'h3;

    // Time-of-day field count (sec, min, hour, date, month, weekday; no year)
    localparam int NUM_FIELDS = 6;

    // Trim: capacitance in 0.5 pF units, fixed offset of 9 pF
    localparam logic [6:0] CAP_BASE_HALF_PF = 7'h12;
    localparam logic [6:0] CAP_TOP_HALF_PF = 7'h20;

    // Interrupt pulse length in ns and derived cycles at 25 ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int IRQ_PULSE_NS = 250;
    localparam int IRQ_PULSE_CYC = IRQ_PULSE_NS / CLK_PERIOD_NS;

    // One alarm: six bytes, each with compare enable in the MSB
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } alarm_s;

    // Current time fields from the counters (year not used)
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } time_s;

    // Array byte write request
    typedef struct packed {
        logic valid;
        logic [8:0] addr;
        logic [7:0] data;
    } arr_wr_s;

endpackage : rtc_ctl_pkg

// ### rtc_host_model.sv
// Host microcontroller model: issues decoded control, alarm and status-read strobes.
// Assumes the bench clock; each strobe lasts one cycle and is driven 1 ns after the edge.
`timescale 1ns/10ps
module rtc_host_model (
    input wire logic clk,
    output logic ctl_wr = 1'b0,
    output logic [2:0] ctl_addr = 3'h0,
    output logic [7:0] ctl_wdata = 8'h00,
    output logic alarm_wr = 1'b0,
    output logic alarm_sel = 1'b0,
    output logic [2:0] alarm_field = 3'h0,
    output logic [7:0] alarm_wdata = 8'h00,
    output logic status_rd_done = 1'b0
);
    // Control write; the status register is never written, and the block forces its bit 3 to zero
    task automatic wr_ctl(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        ctl_addr = a;
        ctl_wdata = d;
        ctl_wr = 1'b1;
        @(posedge clk);
        #1;
        ctl_wr = 1'b0;
    endtask : wr_ctl

    // Alarm byte write: bit 7 enables compare of the field
    task automatic wr_alarm(input logic s, input logic [2:0] f, input logic [7:0] d);
        @(posedge clk);
        #1;
        alarm_sel = s;
        alarm_field = f;
        alarm_wdata = d;
        alarm_wr = 1'b1;
        @(posedge clk);
        #1;
        alarm_wr = 1'b0;
    endtask : wr_alarm

    // End of a status read: eighth clock falling edge seen by the serial slave
    task automatic rd_status();
        @(posedge clk);
        #1;
        status_rd_done = 1'b1;
        @(posedge clk);
        #1;
        status_rd_done = 1'b0;
    endtask : rd_status
endmodule : rtc_host_model
